// File: tb_token_node_host_cmd_status.sv
// self-checking bench for the node host port: commands, status, interrupt and power reset
// assumes the host model runs the bus and line engine events are driven here
`timescale 1ns/10ps
module tb_token_node_host_cmd_status;
  import tnhc_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic power_reset = 1'b0;
  logic ets_a = 1'b1;
  logic ets_b = 1'b1;
  logic test_flag = 1'b0;
  logic rx_active = 1'b0;
  logic [4:0] ev = 5'h00; // token, tx done, tx acked, rx good, recon
  logic [7:0] node_id = 8'h3C;
  wire logic strobe, io_n, rnw, ad_oe, wait_o, req, irq, tx_req, rx_armed, rx_bc, buf_long, ram_we;
  wire logic [7:0] ad_in, ad_out, ram_data;
  wire logic [1:0] tx_page, rx_page;
  wire logic [RAM_AW-1:0] ram_addr;
  logic [7:0] rd;
  int w;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #50 mclk = ~mclk;

  tnhc_top i_tnhc_top (.MCLK(mclk), .RESET_N(reset_n), .ADDR_STROBE(strobe), .IO_REQUEST_N(io_n),
    .READ_NWRITE(rnw), .AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE(ad_oe), .WAIT(wait_o), .REQ(req),
    .HOST_IRQ(irq), .POWER_RESET(power_reset), .EXT_TIMEOUT_SEL_A(ets_a), .EXT_TIMEOUT_SEL_B(ets_b),
    .TEST_FLAG(test_flag), .NODE_ID(node_id), .TOKEN_SEEN(ev[0]), .TX_DONE(ev[1]), .TX_ACKED(ev[2]),
    .RX_ACTIVE(rx_active), .RX_GOOD(ev[3]), .RECON_EVENT(ev[4]), .TX_REQUEST(tx_req), .TX_PAGE(tx_page),
    .RX_ARMED(rx_armed), .RX_PAGE(rx_page), .RX_BROADCAST(rx_bc), .BUF_LONG(buf_long), .RAM_WE(ram_we),
    .RAM_ADDR(ram_addr), .RAM_DATA(ram_data));
  tnhc_host_model i_tnhc_host_model (.clk(mclk), .wait_i(wait_o), .ad_out(ad_out), .addr_strobe(strobe),
    .io_request_n(io_n), .read_nwrite(rnw), .ad_in(ad_in));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string m);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  // host accesses through the model
  task automatic acc(input logic io, input logic rw, input logic a0, input logic [7:0] d);
    i_tnhc_host_model.access(io, rw, a0, d, rd, w);
  endtask
  task automatic cmd(input logic [7:0] d);
    acc(1'b0, 1'b0, PORT_COMMAND, d);
  endtask
  task automatic mask(input logic [7:0] d);
    acc(1'b0, 1'b0, PORT_MASK_STATUS, d);
  endtask
  task automatic st(input logic [7:0] exp);
    acc(1'b0, 1'b1, PORT_MASK_STATUS, 8'hA5);
    check(rd, exp, "status");
  endtask
  // one-cycle line engine pulse, then time for status and irq to settle
  task automatic pulse(input logic [4:0] m);
    ev <= m;
    @(posedge mclk);
    ev <= 5'h00;
    repeat (3) @(posedge mclk);
  endtask

  // a full run takes well under a thousand cycles; stop a hang
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    st(8'hF1);
    check(irq, 1'b1, "irq");
    acc(1'b1, 1'b1, PORT_MASK_STATUS, 8'h00);
    check(w > 1, 1'b1, "wait");
    acc(1'b0, 1'b1, PORT_COMMAND, 8'hA5);
    cmd(8'h1E);
    st(8'hE1);
    check(irq, 1'b0, "irq");
    mask(8'h01);
    check(irq, 1'b1, "irq");
    mask(8'h7A);
    check(irq, 1'b0, "irq");
    $display("test reset and mask done");
    mask(8'h01);
    st(8'hE1);
    cmd(8'h13);
    st(8'hE0);
    check({tx_req, tx_page}, 8'h06, "tx");
    check(irq, 1'b0, "irq");
    pulse(5'h04);
    pulse(5'h02);
    st(8'hE3);
    check({tx_req, irq}, 8'h01, "tx");
    cmd(8'h1B);
    check(tx_page, 2'h3, "page");
    cmd(8'h01);
    st(8'hE0);
    pulse(5'h01);
    check(tx_req, 1'b0, "tx");
    st(8'hE1);
    $display("test transmit done");
    cmd(8'h9C);
    st(8'h61);
    check({rx_armed, rx_bc, rx_page}, 8'h0F, "rx");
    mask(8'h80);
    check(irq, 1'b0, "irq");
    pulse(5'h08);
    st(8'hE1);
    check({rx_armed, irq}, 8'h01, "rx");
    cmd(8'h0C);
    check({rx_armed, rx_bc, rx_page}, 8'h09, "rx");
    rx_active <= 1'b1;
    cmd(8'h02);
    pulse(5'h01);
    check(rx_armed, 1'b1, "rx");
    st(8'h61);
    rx_active <= 1'b0;
    cmd(8'h02);
    pulse(5'h01);
    check(rx_armed, 1'b0, "rx");
    st(8'hE1);
    $display("test receive done");
    cmd(8'h0D);
    check(buf_long, 1'b1, "buf");
    cmd(8'h07);
    cmd(8'h00);
    check({buf_long, tx_req, rx_armed}, 8'h04, "undef");
    st(8'hE1);
    cmd(8'h05);
    check(buf_long, 1'b0, "buf");
    mask(8'h0C);
    test_flag <= 1'b1;
    ets_a <= 1'b0;
    pulse(5'h10);
    st(8'hCD);
    check(irq, 1'b1, "irq");
    cmd(8'h16);
    check(irq, 1'b1, "irq");
    test_flag <= 1'b0;
    ets_a <= 1'b1;
    ets_b <= 1'b0;
    st(8'hA1);
    check(irq, 1'b0, "irq");
    $display("test flags done");
    mask(8'h00);
    power_reset <= 1'b1;
    test_flag <= 1'b1;
    @(posedge mclk);
    #1;
    check({ram_we, ram_addr[6:0]}, 8'h80, "ram");
    check(ram_data, SELFTEST_VAL, "ram");
    @(posedge mclk);
    #1;
    check({ram_we, ram_addr[6:0]}, 8'h81, "ram");
    check(ram_data, node_id, "ram");
    @(posedge mclk);
    st(8'hB1);
    check(irq, 1'b1, "irq");
    power_reset <= 1'b0;
    test_flag <= 1'b0;
    cmd(8'h0E);
    st(8'hA1);
    check(irq, 1'b0, "irq");
    $display("test power reset done");
    finish_test();
  end
endmodule

// File: tnhc_acc_if.sv
// decoded host access strobes passed from the bus front end to the command core
// assumes both ends run on the one block clock
`timescale 1ns/10ps
interface tnhc_acc_if;
  logic wr_mask;
  logic wr_cmd;
  logic [7:0] wdata;
  logic [7:0] status;
  modport port (output wr_mask, output wr_cmd, output wdata, input status);
  modport core (input wr_mask, input wr_cmd, input wdata, output status);
endinterface

// File: tnhc_host_model.sv
// host processor model on the multiplexed address-data bus
// assumes one access at a time, started and ended on a rising clock edge
`timescale 1ns/10ps
module tnhc_host_model (
  // clock and device answer
  input wire logic clk,
  input wire logic wait_i,
  input wire logic [7:0] ad_out,
  // host request lines
  output logic addr_strobe,
  output logic io_request_n,
  output logic read_nwrite,
  output logic [7:0] ad_in
);
  initial begin
    addr_strobe = 1'b1;
    io_request_n = 1'b1;
    read_nwrite = 1'b1;
    ad_in = 8'h5A;
  end

  // address phase at strobe fall, data phase after; held until wait seen low
  task automatic access(input logic io_n, input logic rw, input logic a0, input logic [7:0] d,
    output logic [7:0] rd, output int waits);
    int n;
    n = 0;
    addr_strobe <= 1'b0;
    io_request_n <= io_n;
    read_nwrite <= rw;
    ad_in <= {7'h2A, a0};
    @(posedge clk);
    ad_in <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_i !== 1'b0 && n < 20);
    rd = ad_out;
    waits = n;
    addr_strobe <= 1'b1;
    io_request_n <= 1'b1;
    // released bus must not keep showing the last byte
    ad_in <= ~d;
    repeat (4) @(posedge clk);
  endtask
endmodule

// File: tnhc_host_port.sv
// host bus front end: strobe sampling, port decode, wait hold, status read drive
// assumes host pins are synchronous to the block clock
`timescale 1ns/10ps
module tnhc_host_port
  import tnhc_pkg::*;
#(
  parameter int HOLD_CYC = SERVICE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host pins
  input wire logic addr_strobe,
  input wire logic io_request_n,
  input wire logic read_nwrite,
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic ad_oe,
  output logic wait_o,
  output logic req,
  // decoded accesses
  tnhc_acc_if.port acc
);
  tnhc_hp_state_t state;
  tnhc_hp_state_t next_state;
  logic strobe_q;
  logic is_io;
  logic is_read;
  logic sel_bit;
  logic [SVC_W-1:0] cnt;
  wire strobe_fall = strobe_q && !addr_strobe;
  wire hold_end = (state == HP_HOLD) && (cnt == SVC_W'(HOLD_CYC - 1));
  wire status_read = is_io && is_read && (sel_bit == PORT_MASK_STATUS);

  // every strobe fall is held off with wait, io or not, until serviced
  assign wait_o = strobe_fall || (state == HP_HOLD);
  assign req = is_io && (state != HP_IDLE);
  assign ad_oe = status_read && (state != HP_IDLE);

  // sequence: hold for the service time, then stay until the strobe returns high
  always_comb begin
    next_state = state;
    unique case (state)
      HP_IDLE: if (strobe_fall) next_state = HP_HOLD;
      HP_HOLD: if (hold_end) next_state = HP_DONE;
      HP_DONE: if (addr_strobe) next_state = HP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= HP_IDLE;
      strobe_q <= 1'b1;
      cnt <= '0;
    end else begin
      state <= next_state;
      strobe_q <= addr_strobe;
      cnt <= (state == HP_HOLD) ? cnt + 1'b1 : '0;
    end
  end

  // control lines are taken only at the strobe fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      is_io <= 1'b0;
      is_read <= 1'b0;
      sel_bit <= 1'b0;
      ad_out <= 8'h00;
    end else if (strobe_fall) begin
      is_io <= !io_request_n;
      is_read <= read_nwrite;
      sel_bit <= ad_in[0];
      ad_out <= acc.status;
    end
  end

  // write data is taken on the last held cycle, giving the host the whole wait to settle it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc.wr_mask <= 1'b0;
      acc.wr_cmd <= 1'b0;
      acc.wdata <= 8'h00;
    end else begin
      acc.wr_mask <= hold_end && is_io && !is_read && (sel_bit == PORT_MASK_STATUS);
      acc.wr_cmd <= hold_end && is_io && !is_read && (sel_bit == PORT_COMMAND);
      if (hold_end) acc.wdata <= ad_in;
    end
  end
endmodule

// File: tnhc_pkg.sv
// constants, command codes, status layout and state types of the node host port
// assumes a single 10 MHz clock shared by every module of the block
package tnhc_pkg;
  // clock and host service timing
  localparam int CLK_NS = 100;
  localparam int SERVICE_NS = 200;
  localparam int SERVICE_CYC = (SERVICE_NS / CLK_NS) < 1 ? 1 : (SERVICE_NS / CLK_NS);
  localparam int SVC_W = 4;
  // port select on address-data bit 0
  localparam logic PORT_MASK_STATUS = 1'b0;
  localparam logic PORT_COMMAND = 1'b1;
  // command op field and codes
  localparam int CMD_OP_MSB = 2;
  localparam logic [2:0] CMD_TX_OFF = 3'h1;
  localparam logic [2:0] CMD_RX_OFF = 3'h2;
  localparam logic [2:0] CMD_TX_EN = 3'h3;
  localparam logic [2:0] CMD_RX_EN = 3'h4;
  localparam logic [2:0] CMD_BUF_SIZE = 3'h5;
  localparam logic [2:0] CMD_CLR_FLAGS = 3'h6;
  // command argument bits
  localparam int CMD_PAGE_LSB = 3;
  localparam int CMD_BCAST = 7;
  localparam int CMD_SIZE = 3;
  localparam int CMD_CLR_RECON = 4;
  localparam int CMD_CLR_POR = 3;
  // status bit positions
  localparam int ST_TA = 0;
  localparam int ST_TMA = 1;
  localparam int ST_RECON = 2;
  localparam int ST_TEST = 3;
  localparam int ST_POR = 4;
  localparam int ST_ETSA = 5;
  localparam int ST_ETSB = 6;
  localparam int ST_RI = 7;
  // reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [1:0] PAGE_RST = 2'h0;
  // self-test pattern written to the buffer on power reset
  localparam int RAM_AW = 11;
  localparam logic [7:0] SELFTEST_VAL = 8'hD1;
  localparam logic [10:0] SELFTEST_ADDR = 11'h000;
  localparam logic [10:0] NODE_ID_ADDR = 11'h001;

  typedef enum logic [2:0] {HP_IDLE = 3'b001, HP_HOLD = 3'b010, HP_DONE = 3'b100} tnhc_hp_state_t;
  typedef enum logic [2:0] {SW_IDLE = 3'b001, SW_ADDR0 = 3'b010, SW_ADDR1 = 3'b100} tnhc_sw_state_t;

  // page number carried in bits 4:3 of transmit and receive commands
  function automatic logic [1:0] cmd_page(input logic [7:0] c);
    cmd_page = c[CMD_PAGE_LSB +: 2];
  endfunction
endpackage

// File: tnhc_selftest_wr.sv
// writes the self-test byte and node id into the two lowest buffer bytes
// assumes the buffer accepts one write per clock while this runs
`timescale 1ns/10ps
module tnhc_selftest_wr
  import tnhc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // trigger and node id
  input wire logic start,
  input wire logic [7:0] node_id,
  // buffer write port
  output logic ram_we,
  output logic [RAM_AW-1:0] ram_addr,
  output logic [7:0] ram_data
);
  tnhc_sw_state_t state;
  tnhc_sw_state_t next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      SW_IDLE: if (start) next_state = SW_ADDR0;
      SW_ADDR0: next_state = SW_ADDR1;
      SW_ADDR1: next_state = SW_IDLE;
    endcase
  end

  // two back to back writes: pattern at byte 0, id at byte 1
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= SW_IDLE;
      ram_we <= 1'b0;
      ram_addr <= SELFTEST_ADDR;
      ram_data <= 8'h00;
    end else begin
      state <= next_state;
      ram_we <= (next_state != SW_IDLE);
      ram_addr <= (next_state == SW_ADDR1) ? NODE_ID_ADDR : SELFTEST_ADDR;
      ram_data <= (next_state == SW_ADDR1) ? node_id : SELFTEST_VAL;
    end
  end
endmodule

// File: tnhc_top.sv
// command, status and interrupt core of the token node host interface
// assumes the line engine reports token, transmit and receive events as one-cycle pulses
// How it works
// - strobe fall with io request low picks port from bit 0 and read/write
// - wait is raised on every host access attempt until serviced
// - transmitter off cancels pending transmit; free bit set at next token
// - receiver off cancels pending receive, inhibit at next token, unless packet arriving
// - transmit enable clears free and acked bits, sends from page at token
// - receive enable clears inhibit, arms page; b adds broadcasts; reception sets inhibit
// - buffer size command records 1K short or 2K long buffer
// - clear flags clears reconfiguration flag if r, power flag if p
// - bit 0 reads one when transmitter is free and previous transmit done
// - bit 1 reads one when previous transmit was acknowledged
// - bit 2 set on idle-timeout reconfiguration, held until clear flags or power reset
// - bit 3 is a diagnostic flag, zero in normal operation
// - bit 4 set by active power reset, held until clear flags
// - bits 5 and 6 follow the two extended timeout select pins
// - bit 7 reads one while no messages are accepted
// - power reset forces status to 1xx10001, pin bits kept
// - power flag drives the interrupt regardless of the mask
// - mask bits 7,3,2,0 enable their status conditions; others ignored
// - interrupt is high while an enabled condition holds, drops otherwise
// - power reset writes D1 to buffer byte 0 and node id to byte 1
`timescale 1ns/10ps
module tnhc_top
  import tnhc_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // host bus
  input wire logic ADDR_STROBE,
  input wire logic IO_REQUEST_N,
  input wire logic READ_NWRITE,
  input wire logic [7:0] AD_IN,
  output logic [7:0] AD_OUT,
  output logic AD_OE,
  output logic WAIT,
  output logic REQ,
  output logic HOST_IRQ,
  // node straps and power reset
  input wire logic POWER_RESET,
  input wire logic EXT_TIMEOUT_SEL_A,
  input wire logic EXT_TIMEOUT_SEL_B,
  input wire logic TEST_FLAG,
  input wire logic [7:0] NODE_ID,
  // line engine events
  input wire logic TOKEN_SEEN,
  input wire logic TX_DONE,
  input wire logic TX_ACKED,
  input wire logic RX_ACTIVE,
  input wire logic RX_GOOD,
  input wire logic RECON_EVENT,
  // line engine controls
  output logic TX_REQUEST,
  output logic [1:0] TX_PAGE,
  output logic RX_ARMED,
  output logic [1:0] RX_PAGE,
  output logic RX_BROADCAST,
  output logic BUF_LONG,
  // buffer write port
  output logic RAM_WE,
  output logic [RAM_AW-1:0] RAM_ADDR,
  output logic [7:0] RAM_DATA
);
  import tnhc_pkg::*;

  tnhc_acc_if acc ();

  logic transmitter_free;
  logic transmit_acked;
  logic recon_flag;
  logic power_flag;
  logic receive_inhibited;
  logic tx_cancel;
  logic rx_cancel;
  logic tx_pend;
  logic rx_armed;
  logic [7:0] interrupt_enable_mask;
  logic power_q;
  logic irq;

  tnhc_host_port #(
    .HOLD_CYC(SERVICE_CYC)
  ) i_tnhc_host_port (
    .clk(MCLK),
    .rst_n(RESET_N),
    .addr_strobe(ADDR_STROBE),
    .io_request_n(IO_REQUEST_N),
    .read_nwrite(READ_NWRITE),
    .ad_in(AD_IN),
    .ad_out(AD_OUT),
    .ad_oe(AD_OE),
    .wait_o(WAIT),
    .req(REQ),
    .acc(acc.port)
  );

  // a fresh power reset edge restarts the buffer self-test writes
  wire power_rise = POWER_RESET && !power_q;

  tnhc_selftest_wr i_tnhc_selftest_wr (
    .clk(MCLK),
    .rst_n(RESET_N),
    .start(power_rise),
    .node_id(NODE_ID),
    .ram_we(RAM_WE),
    .ram_addr(RAM_ADDR),
    .ram_data(RAM_DATA)
  );

  // command decode on the low three bits; other codes match no strobe
  wire [2:0] cmd_op = acc.wdata[CMD_OP_MSB:0];
  wire do_tx_off = acc.wr_cmd && (cmd_op == CMD_TX_OFF);
  wire do_rx_off = acc.wr_cmd && (cmd_op == CMD_RX_OFF);
  wire do_tx_en = acc.wr_cmd && (cmd_op == CMD_TX_EN);
  wire do_rx_en = acc.wr_cmd && (cmd_op == CMD_RX_EN);
  wire do_buf = acc.wr_cmd && (cmd_op == CMD_BUF_SIZE);
  wire do_clr = acc.wr_cmd && (cmd_op == CMD_CLR_FLAGS);
  wire clr_recon = do_clr && acc.wdata[CMD_CLR_RECON];
  wire clr_power = do_clr && acc.wdata[CMD_CLR_POR];
  // a receiver-off command is void once a packet has begun arriving
  wire rx_off_ok = do_rx_off && !RX_ACTIVE;
  wire rx_landed = RX_GOOD && rx_armed;

  // next values: power reset first, then sets, then clears
  logic next_free;
  logic next_acked;
  logic next_recon;
  logic next_power;
  logic next_inhib;
  logic next_tx_cancel;
  logic next_rx_cancel;
  logic next_tx_pend;
  logic next_rx_armed;

  // transmit side flags
  assign next_free = POWER_RESET ? 1'b1 :
                     (TX_DONE || (TOKEN_SEEN && tx_cancel)) ? 1'b1 :
                     do_tx_en ? 1'b0 : transmitter_free;
  assign next_acked = POWER_RESET ? 1'b0 :
                      TX_ACKED ? 1'b1 :
                      do_tx_en ? 1'b0 : transmit_acked;
  assign next_tx_pend = POWER_RESET ? 1'b0 :
                        do_tx_en ? 1'b1 :
                        (do_tx_off || TX_DONE) ? 1'b0 : tx_pend;
  assign next_tx_cancel = POWER_RESET ? 1'b0 :
                          do_tx_off ? 1'b1 :
                          TOKEN_SEEN ? 1'b0 : tx_cancel;

  // sticky flags; a set in the clearing cycle wins
  assign next_recon = POWER_RESET ? 1'b0 :
                      RECON_EVENT ? 1'b1 :
                      clr_recon ? 1'b0 : recon_flag;
  assign next_power = POWER_RESET ? 1'b1 :
                      clr_power ? 1'b0 : power_flag;

  // receive side flags
  assign next_inhib = POWER_RESET ? 1'b1 :
                      (rx_landed || (TOKEN_SEEN && rx_cancel)) ? 1'b1 :
                      do_rx_en ? 1'b0 : receive_inhibited;
  assign next_rx_armed = POWER_RESET ? 1'b0 :
                         do_rx_en ? 1'b1 :
                         (rx_off_ok || rx_landed) ? 1'b0 : rx_armed;
  assign next_rx_cancel = POWER_RESET ? 1'b0 :
                          rx_off_ok ? 1'b1 :
                          TOKEN_SEEN ? 1'b0 : rx_cancel;

  // status flag registers; the chip reset looks like a power reset to software
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      transmitter_free <= 1'b1;
      transmit_acked <= 1'b0;
      recon_flag <= 1'b0;
      power_flag <= 1'b1;
      receive_inhibited <= 1'b1;
    end else begin
      transmitter_free <= next_free;
      transmit_acked <= next_acked;
      recon_flag <= next_recon;
      power_flag <= next_power;
      receive_inhibited <= next_inhib;
    end
  end

  // pending request registers seen by the line engine
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      tx_pend <= 1'b0;
      tx_cancel <= 1'b0;
      rx_armed <= 1'b0;
      rx_cancel <= 1'b0;
      power_q <= 1'b0;
    end else begin
      tx_pend <= next_tx_pend;
      tx_cancel <= next_tx_cancel;
      rx_armed <= next_rx_armed;
      rx_cancel <= next_rx_cancel;
      power_q <= POWER_RESET;
    end
  end

  // page, broadcast and buffer size settings held from the last command
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      TX_PAGE <= PAGE_RST;
      RX_PAGE <= PAGE_RST;
      RX_BROADCAST <= 1'b0;
      BUF_LONG <= 1'b0;
    end else begin
      if (do_tx_en) TX_PAGE <= cmd_page(acc.wdata);
      if (do_rx_en) RX_PAGE <= cmd_page(acc.wdata);
      if (do_rx_en) RX_BROADCAST <= acc.wdata[CMD_BCAST];
      if (do_buf) BUF_LONG <= acc.wdata[CMD_SIZE];
    end
  end

  assign TX_REQUEST = tx_pend;
  assign RX_ARMED = rx_armed;

  // interrupt mask register, write only
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      interrupt_enable_mask <= MASK_RST;
    end else if (acc.wr_mask) begin
      interrupt_enable_mask <= acc.wdata;
    end
  end

  // status word; pin bits pass straight through so power reset leaves them alone
  assign acc.status[ST_TA] = transmitter_free;
  assign acc.status[ST_TMA] = transmit_acked;
  assign acc.status[ST_RECON] = recon_flag;
  // the diagnostic bit is forced low with the rest of the power reset pattern
  assign acc.status[ST_TEST] = TEST_FLAG && !POWER_RESET;
  assign acc.status[ST_POR] = power_flag;
  assign acc.status[ST_ETSA] = EXT_TIMEOUT_SEL_A;
  assign acc.status[ST_ETSB] = EXT_TIMEOUT_SEL_B;
  assign acc.status[ST_RI] = receive_inhibited;

  // interrupt is a level; it follows its sources with one register of delay
  wire [7:0] st = acc.status;
  wire [7:0] m = interrupt_enable_mask;
  wire masked_irq = (m[ST_RI] && st[ST_RI]) ||
                    (m[ST_TEST] && st[ST_TEST]) ||
                    (m[ST_RECON] && st[ST_RECON]) ||
                    (m[ST_TA] && st[ST_TA]);
  wire next_irq = power_flag || masked_irq;

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  assign HOST_IRQ = irq;
endmodule

// File: tnhc_top_asserts.sv
// checker for the node host port: host bus timing, power reset write-back and interrupt
// assumes it is bound to tnhc_top and sees only its ports
`timescale 1ns/10ps
module tnhc_top_asserts
  import tnhc_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // host bus
  input wire logic ADDR_STROBE,
  input wire logic IO_REQUEST_N,
  input wire logic READ_NWRITE,
  input wire logic [7:0] AD_IN,
  input wire logic AD_OE,
  input wire logic WAIT,
  input wire logic REQ,
  input wire logic HOST_IRQ,
  // power reset and buffer port
  input wire logic POWER_RESET,
  input wire logic [7:0] NODE_ID,
  input wire logic RAM_WE,
  input wire logic [tnhc_pkg::RAM_AW-1:0] RAM_ADDR,
  input wire logic [7:0] RAM_DATA
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  // wait covers the strobe cycle and the two hold cycles, then drops
  AST_WAIT_HOLD: assert property ($fell(ADDR_STROBE) |-> WAIT ##1 WAIT [*2] ##1 !WAIT)
    else $error("wait not held for the service time");
  AST_REQ_IO: assert property ($fell(ADDR_STROBE) && !IO_REQUEST_N |-> ##1 REQ)
    else $error("request not acknowledged");
  AST_REQ_FOREIGN: assert property ($fell(ADDR_STROBE) && IO_REQUEST_N |-> ##1 !REQ [*3])
    else $error("request raised on a foreign access");
  AST_RES_READ: assert property ($fell(ADDR_STROBE) && READ_NWRITE && AD_IN[0] |-> ##1 !AD_OE [*3])
    else $error("bus driven on reserved read");
  AST_STAT_READ: assert property ($fell(ADDR_STROBE) && !IO_REQUEST_N && READ_NWRITE && !AD_IN[0]
    |-> ##1 AD_OE [*3])
    else $error("status not driven on read");
  // nothing moves on the host side once the strobe has stayed high
  AST_IDLE_QUIET: assert property (ADDR_STROBE [*4] |-> !WAIT && !REQ && !AD_OE)
    else $error("host outputs active while idle");
  AST_IRQ_POR: assert property (POWER_RESET |-> ##2 HOST_IRQ)
    else $error("power reset did not interrupt");
  AST_RAM_SEQ: assert property ($rose(POWER_RESET) |-> ##1 RAM_WE && RAM_ADDR == SELFTEST_ADDR
    && RAM_DATA == SELFTEST_VAL ##1 RAM_WE && RAM_ADDR == NODE_ID_ADDR && RAM_DATA == NODE_ID ##1 !RAM_WE)
    else $error("self-test write sequence wrong");
  AST_RAM_IDLE: assert property (RAM_WE |-> $past(POWER_RESET) || $past(POWER_RESET, 2))
    else $error("buffer written without power reset");

  // main scenarios reached
  COV_READ: cover property ($fell(ADDR_STROBE) && !IO_REQUEST_N && READ_NWRITE);
  COV_WRITE: cover property ($fell(ADDR_STROBE) && !IO_REQUEST_N && !READ_NWRITE);
  COV_POR: cover property ($rose(POWER_RESET));
endmodule

bind tnhc_top tnhc_top_asserts i_tnhc_top_asserts (.MCLK(MCLK), .RESET_N(RESET_N),
  .ADDR_STROBE(ADDR_STROBE), .IO_REQUEST_N(IO_REQUEST_N), .READ_NWRITE(READ_NWRITE), .AD_IN(AD_IN),
  .AD_OE(AD_OE), .WAIT(WAIT), .REQ(REQ), .HOST_IRQ(HOST_IRQ), .POWER_RESET(POWER_RESET),
  .NODE_ID(NODE_ID), .RAM_WE(RAM_WE), .RAM_ADDR(RAM_ADDR), .RAM_DATA(RAM_DATA));
